// [core/pomc_pkg.sv]
package pomc_pkg;

  // Operating modes
  typedef enum logic [1:0] {
    POMC_STOP,
    POMC_STARTUP,
    POMC_RUN,
    POMC_HOLD
  } pomc_mode_t;

  // Run cycle phases
  typedef enum logic [2:0] {
    POMC_PH_IDLE,
    POMC_PH_CLR_IN,
    POMC_PH_STARTUP,
    POMC_PH_CLR_OUT,
    POMC_PH_READ_IN,
    POMC_PH_MAIN,
    POMC_PH_WRITE_OUT
  } pomc_phase_t;

  // Register map
  localparam logic [3:0] POMC_ADDR_CTRL    = 4'h0;
  localparam logic [3:0] POMC_ADDR_STATUS  = 4'h1;
  localparam logic [3:0] POMC_ADDR_BRK     = 4'h2;
  localparam logic [3:0] POMC_ADDR_CYCLIM  = 4'h3;
  localparam logic [3:0] POMC_ADDR_CYCCNT  = 4'h4;

  // CTRL write bits (command pulses)
  localparam int POMC_CTRL_RUN_REQ   = 0;
  localparam int POMC_CTRL_STOP_REQ  = 1;
  localparam int POMC_CTRL_STEP      = 2;
  localparam int POMC_CTRL_RESUME    = 3;
  localparam int POMC_CTRL_OVR_RESET = 4;
  localparam int POMC_CTRL_RELOAD    = 5;
  localparam int POMC_CTRL_COLD_OK   = 6;

  // Breakpoint register: bits 2:0 active breakpoints
  localparam int POMC_NUM_BRK = 3;
  localparam logic [1:0] POMC_STEP_MAX_BRK = 2'h2;

  // Timing
  localparam longint POMC_CLK_HZ       = 250000000;
  localparam longint POMC_BLINK_MIN_MS = 3000;
  localparam longint POMC_WDOG_MS      = 100;
  localparam longint POMC_CYC_MIN_MS   = 1;
  localparam longint POMC_BLINK_HALF_MS = 250;
  localparam longint POMC_BLINK_CYC = POMC_CLK_HZ / 1000 * POMC_BLINK_MIN_MS;
  localparam longint POMC_WDOG_CYC  = POMC_CLK_HZ / 1000 * POMC_WDOG_MS;
  localparam longint POMC_CYC_MIN_CYC = POMC_CLK_HZ / 1000 * POMC_CYC_MIN_MS;
  localparam longint POMC_HALF_CYC  = POMC_CLK_HZ / 1000 * POMC_BLINK_HALF_MS;

  localparam logic [31:0] POMC_CYCLIM_RST = 32'h017D7840;

  // Signals to the process I/O side
  typedef struct packed {
    logic output_disable;
    logic clr_input_image;
    logic clr_output_image;
    logic read_input_image;
    logic write_output_image;
    logic run_startup_routine;
    logic run_cold_start_routine;
    logic run_main_cycle_routine;
    logic timers_enable;
    logic erase_user_memory;
  } pomc_io_t;

endpackage

// [core/pomc_mode_ctrl.sv]
`timescale 1ns/1ps
module pomc_mode_ctrl
  import pomc_pkg::*;
#(
  parameter longint BLINK_CYC = POMC_BLINK_CYC,
  parameter longint WDOG_CYC  = POMC_WDOG_CYC,
  parameter longint HALF_CYC  = POMC_HALF_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        phase_done,
  input  wire logic        brk_hit,
  input  wire logic        cold_start_present,
  output pomc_io_t         io_ctl,
  output logic             run_led,
  output logic             stop_led,
  output pomc_mode_t       mode
);

  // Bus decode; CTRL bits are one-shot commands, nothing of them is stored
  // Map: 0 control, 1 status, 2 breakpoints, 3 cycle limit, 4 last cycle
  // A command that the current mode cannot take is dropped silently
  wire wr_ctrl   = reg_wr && (reg_addr == POMC_ADDR_CTRL);
  wire wr_brk    = reg_wr && (reg_addr == POMC_ADDR_BRK);
  wire wr_cyclim = reg_wr && (reg_addr == POMC_ADDR_CYCLIM);
  // Command strobes, one per control bit
  wire cmd_run   = wr_ctrl && reg_wdata[POMC_CTRL_RUN_REQ];
  wire cmd_stop  = wr_ctrl && reg_wdata[POMC_CTRL_STOP_REQ];
  wire cmd_step  = wr_ctrl && reg_wdata[POMC_CTRL_STEP];
  wire cmd_res   = wr_ctrl && reg_wdata[POMC_CTRL_RESUME];
  wire cmd_ovr   = wr_ctrl && reg_wdata[POMC_CTRL_OVR_RESET];
  wire cmd_rld   = wr_ctrl && reg_wdata[POMC_CTRL_RELOAD];
  wire cmd_cold  = wr_ctrl && reg_wdata[POMC_CTRL_COLD_OK];

  // Sequencer state
  pomc_mode_t  mode_r, mode_nxt;
  pomc_phase_t ph_r, ph_nxt;

  // Software visible settings
  logic [POMC_NUM_BRK-1:0] brk_r;
  logic [31:0] cyclim_r;

  // Supervision
  logic [31:0] cyccnt_r;
  logic [31:0] cyc_last_r;
  logic        wd_err_r;
  logic        cyc_err_r;

  // Lamp timing
  logic [31:0] blink_cnt_r;
  logic [31:0] half_cnt_r;
  logic        blink_ph_r;

  // One-cycle pulses and resynchronised levels
  logic        erase_r;
  logic        cold_r;
  logic        step_pend_r;
  logic        cold_meta_r;
  logic        cold_sync_r;

  // Count of defined breakpoints
  function automatic logic [1:0] pomc_popcnt(input logic [2:0] v);
    pomc_popcnt = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction

  // Mode transition decode, used by flags, blink window and pulses
  function automatic logic pomc_is_entry(input pomc_mode_t cur,
                                         input pomc_mode_t nxt,
                                         input pomc_mode_t from,
                                         input pomc_mode_t to);
    pomc_is_entry = (cur == from) && (nxt == to);
  endfunction

  // Cold-start presence is a level from outside; two flops keep a change
  // near an edge from splitting the restart decision
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cold_meta_r <= 1'b0;
      cold_sync_r <= 1'b0;
    end else begin
      cold_meta_r <= cold_start_present;
      cold_sync_r <= cold_meta_r;
    end
  end

  wire [1:0] brk_n     = pomc_popcnt(brk_r);
  wire       step_ok   = (brk_n <= POMC_STEP_MAX_BRK);
  wire       brk_act   = |brk_r;
  wire       wd_trip   = (mode_r == POMC_RUN) && (cyccnt_r >= WDOG_CYC[31:0]);
  wire       cyc_trip  = (mode_r == POMC_RUN) && (cyccnt_r >= cyclim_r);
  wire       trip      = wd_trip || cyc_trip;
  wire       restart_ok = !wd_err_r || cmd_ovr || cmd_rld ||
                          (cold_sync_r && cmd_cold);
  wire       blinking  = (blink_cnt_r != 32'h0000_0000);
  wire       enter_su  = pomc_is_entry(mode_r, mode_nxt, POMC_STOP, POMC_STARTUP);

  // Mode sequencer; single enum register keeps one mode at a time
  // Stop: waits for a run or cold-start command that the error latch allows
  // Start-up: clears the input image, then runs the start-up routine; no
  // time limit applies, only a stop command ends it early
  // Run: read inputs, main routine, write outputs; a supervision trip or a
  // stop command ends in stop, a breakpoint in hold
  // Hold: code and timers frozen until resume, step or stop
  always_comb begin
    mode_nxt = mode_r;
    ph_nxt   = ph_r;
    unique case (mode_r)
      // No program runs, images untouched
      POMC_STOP: begin
        ph_nxt = POMC_PH_IDLE;
        if ((cmd_run || cmd_cold) && restart_ok && !cmd_stop) begin
          mode_nxt = POMC_STARTUP;
          ph_nxt   = POMC_PH_CLR_IN;
        end
      end
      // Two phases, each ended by the I/O side
      POMC_STARTUP: begin
        if (cmd_stop) begin
          mode_nxt = POMC_STOP;
          ph_nxt   = POMC_PH_IDLE;
        end else if (ph_r == POMC_PH_CLR_IN) begin
          if (phase_done) ph_nxt = POMC_PH_STARTUP;
        end else if (phase_done) begin
          mode_nxt = POMC_RUN;
          ph_nxt   = POMC_PH_CLR_OUT;
        end
      end
      // Supervision first, then breakpoint, then phase progress
      POMC_RUN: begin
        if (trip || cmd_stop) begin
          mode_nxt = POMC_STOP;
          ph_nxt   = POMC_PH_IDLE;
        end else if (brk_hit && brk_act && ph_r == POMC_PH_MAIN) begin
          mode_nxt = POMC_HOLD;
        end else if (phase_done) begin
          case (ph_r)
            POMC_PH_CLR_OUT:   ph_nxt = POMC_PH_READ_IN;
            POMC_PH_READ_IN:   ph_nxt = POMC_PH_MAIN;
            POMC_PH_MAIN:      ph_nxt = POMC_PH_WRITE_OUT;
            POMC_PH_WRITE_OUT: ph_nxt = POMC_PH_READ_IN;
            default:           ph_nxt = POMC_PH_READ_IN;
          endcase
        end
      end
      // Phase kept, so the cycle resumes where it halted
      POMC_HOLD: begin
        if (cmd_stop) begin
          mode_nxt = POMC_STOP;
          ph_nxt   = POMC_PH_IDLE;
        end else if (cmd_res || (cmd_step && step_ok)) begin
          mode_nxt = POMC_RUN;
        end
      end
      default: begin
        mode_nxt = POMC_STOP;
        ph_nxt   = POMC_PH_IDLE;
      end
    endcase
  end

  // Mode and phase registers
  // Reset lands in stop with no phase pending
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_r <= POMC_STOP;
      ph_r   <= POMC_PH_IDLE;
    end else begin
      mode_r <= mode_nxt;
      ph_r   <= ph_nxt;
    end
  end

  // Software registers; breakpoints can be written in any mode, hold included
  // A cycle limit below the 1 ms floor is refused and the old one kept
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      brk_r    <= '0;
      cyclim_r <= POMC_CYCLIM_RST;
    end else begin
      if (wr_brk) brk_r <= reg_wdata[POMC_NUM_BRK-1:0];
      if (wr_cyclim && reg_wdata >= POMC_CYC_MIN_CYC[31:0])
        cyclim_r <= reg_wdata;
    end
  end

  // Cycle timer restarts at each output write, frozen in hold
  // The same count feeds the fixed watchdog and the programmable limit, so
  // a cycle that overruns either ends in stop on the next edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cyccnt_r   <= '0;
      cyc_last_r <= '0;
    end else if (mode_r == POMC_HOLD) begin
      cyccnt_r <= cyccnt_r;
    end else if (mode_r != POMC_RUN) begin
      cyccnt_r <= '0;
    end else if (ph_r == POMC_PH_WRITE_OUT && phase_done) begin
      cyc_last_r <= cyccnt_r;
      cyccnt_r   <= '0;
    end else begin
      cyccnt_r <= cyccnt_r + 32'h1;
    end
  end

  // Error flags: watchdog latch held until a legal restart path
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wd_err_r  <= 1'b0;
      cyc_err_r <= 1'b0;
    end else begin
      // A trip in the same cycle as a clear keeps the error
      if (wd_trip) wd_err_r <= 1'b1;
      else if (enter_su) wd_err_r <= 1'b0;
      else if (mode_r == POMC_STOP && (cmd_ovr || cmd_rld)) wd_err_r <= 1'b0;
      if (cyc_trip) cyc_err_r <= 1'b1;
      else if (mode_nxt == POMC_STARTUP) cyc_err_r <= 1'b0;
    end
  end

  // Run LED blink window of at least 3 s, survives a forced stop
  // The blink phase runs free so that hold and start-up share one rhythm
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      blink_cnt_r <= '0;
      half_cnt_r  <= '0;
      blink_ph_r  <= 1'b0;
    end else begin
      if (enter_su)
        blink_cnt_r <= BLINK_CYC[31:0];
      else if (blinking)
        blink_cnt_r <= blink_cnt_r - 32'h1;
      if (half_cnt_r >= HALF_CYC[31:0] - 32'h1) begin
        half_cnt_r <= '0;
        blink_ph_r <= !blink_ph_r;
      end else begin
        half_cnt_r <= half_cnt_r + 32'h1;
      end
    end
  end

  // Overall reset and cold-start pulses
  // Overall reset is honoured only in stop, never while the program runs
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      erase_r     <= 1'b0;
      cold_r      <= 1'b0;
      step_pend_r <= 1'b0;
    end else begin
      erase_r     <= cmd_ovr && (mode_r == POMC_STOP);
      cold_r      <= enter_su && wd_err_r;
      step_pend_r <= (mode_r == POMC_HOLD) && cmd_step && step_ok;
    end
  end

  // Next values of the registered outputs
  // Outputs are derived from the next mode and phase, so the lamps, the I/O
  // controls and the mode port change on one edge; the erase and cold-start pulses follow one edge later
  wire run_nxt      = (mode_nxt == POMC_RUN);
  wire blink_on     = (blinking || mode_r == POMC_HOLD) ? blink_ph_r : 1'b0;

  // Output disable released only in run; central and decentral alike
  wire od_nxt       = !run_nxt;

  // Image and routine requests, one per phase, dropped when run is left
  wire clr_in_nxt   = (ph_nxt == POMC_PH_CLR_IN);
  wire su_nxt       = (ph_nxt == POMC_PH_STARTUP) && (mode_nxt == POMC_STARTUP);
  wire clr_out_nxt  = (ph_nxt == POMC_PH_CLR_OUT) && run_nxt;
  wire rd_in_nxt    = (ph_nxt == POMC_PH_READ_IN) && run_nxt;
  wire wr_out_nxt   = (ph_nxt == POMC_PH_WRITE_OUT) && run_nxt;

  // Main routine in run; a granted single step lets it go on once more
  wire main_nxt     = (ph_nxt == POMC_PH_MAIN) && (run_nxt || step_pend_r);

  // Program timers and counters frozen outside run
  wire tmr_nxt      = run_nxt;

  // Run lamp steady in run once the start-up blink window has closed
  wire run_led_nxt  = (run_nxt && !blinking) ? 1'b1 : blink_on;

  // Stop lamp lit whenever the program is not cycling
  wire stop_led_nxt = !run_nxt;

  // Output registers; reset is stop, so output disable comes up set
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      io_ctl   <= '{output_disable: 1'b1, default: 1'b0};
      run_led  <= 1'b0;
      stop_led <= 1'b1;
      mode     <= POMC_STOP;
    end else begin
      mode                          <= mode_nxt;
      io_ctl.output_disable         <= od_nxt;
      io_ctl.clr_input_image        <= clr_in_nxt;
      io_ctl.run_startup_routine    <= su_nxt;
      io_ctl.run_cold_start_routine <= cold_r;
      io_ctl.clr_output_image       <= clr_out_nxt;
      io_ctl.read_input_image       <= rd_in_nxt;
      io_ctl.run_main_cycle_routine <= main_nxt;
      io_ctl.write_output_image     <= wr_out_nxt;
      io_ctl.timers_enable          <= tmr_nxt;
      io_ctl.erase_user_memory      <= erase_r;
      run_led                       <= run_led_nxt;
      stop_led                      <= stop_led_nxt;
    end
  end

  // Status word layout
  wire [31:0] status_word = {24'h0,
                             step_ok,     // Single step allowed
                             cyc_err_r,   // Cycle limit exceeded
                             wd_err_r,    // Watchdog error latched
                             blinking,    // Start-up blink window open
                             2'h0,
                             mode_r};     // Current mode

  // Read mux; unmapped addresses read as zero
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_addr == POMC_ADDR_STATUS)
      rdata_nxt = status_word;
    else if (reg_addr == POMC_ADDR_BRK)
      rdata_nxt = {29'h0, brk_r};
    else if (reg_addr == POMC_ADDR_CYCLIM)
      rdata_nxt = cyclim_r;
    else if (reg_addr == POMC_ADDR_CYCCNT)
      rdata_nxt = cyc_last_r;
  end

  // Read data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) reg_rdata <= '0;
    else       reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
  end

endmodule // pomc_mode_ctrl

// [sim/pomc_mode_ctrl_asserts.sv]
`timescale 1ns/1ps
module pomc_mode_ctrl_asserts
  import pomc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic       phase_done,
  input wire pomc_io_t   io_ctl,
  input wire logic       stop_led,
  input wire pomc_mode_t mode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Outputs and lamps that each mode must show
  stop_safe_a: assert property ($past(nrst) && mode == POMC_STOP |->
    io_ctl.output_disable && stop_led && !io_ctl.run_main_cycle_routine) else $error("stop");
  startup_od_a: assert property (mode == POMC_STARTUP |->
    io_ctl.output_disable && stop_led) else $error("startup");
  run_open_a: assert property (mode == POMC_RUN |->
    !io_ctl.output_disable && !stop_led) else $error("run");
  hold_frozen_a: assert property (mode == POMC_HOLD |-> io_ctl.output_disable &&
    stop_led && !io_ctl.timers_enable && !io_ctl.run_main_cycle_routine) else $error("hold");
  no_jump_a: assert property ($past(mode) == POMC_STOP |->
    mode != POMC_RUN && mode != POMC_HOLD) else $error("jump");
  // Phase order of start-up and of the run cycle
  startup_seq_a: assert property (mode == POMC_STARTUP && io_ctl.clr_input_image &&
    phase_done && !reg_wr |=> io_ctl.run_startup_routine) else $error("startup seq");
  run_entry_a: assert property (mode == POMC_STARTUP && io_ctl.run_startup_routine &&
    phase_done && !reg_wr |=> mode == POMC_RUN && io_ctl.clr_output_image) else $error("entry");
  cycle_order_a: assert property (mode == POMC_RUN && io_ctl.read_input_image &&
    phase_done && !reg_wr |=> io_ctl.run_main_cycle_routine) else $error("order");
endmodule // pomc_mode_ctrl_asserts

bind pomc_mode_ctrl pomc_mode_ctrl_asserts u_pomc_mode_ctrl_asserts (.clk_sys(clk_sys),
  .nrst(nrst), .reg_wr(reg_wr), .phase_done(phase_done), .io_ctl(io_ctl),
  .stop_led(stop_led), .mode(mode));

// [sim/pomc_io_model.sv]
`timescale 1ns/1ps
module pomc_io_model
  import pomc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire pomc_io_t   io_ctl,
  input  wire logic [7:0] dly,
  output logic            phase_done
);
  logic [7:0] cnt_r;
  logic       busy;
  // Any phase request keeps the I/O side busy
  assign busy = io_ctl.clr_input_image | io_ctl.run_startup_routine | io_ctl.clr_output_image
              | io_ctl.read_input_image | io_ctl.run_main_cycle_routine | io_ctl.write_output_image;
  // Finish each job after dly+1 cycles with a one-cycle done pulse
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r      <= 8'h00;
      phase_done <= 1'b0;
    end else if (!busy || phase_done) begin
      cnt_r      <= 8'h00;
      phase_done <= 1'b0;
    end else if (cnt_r >= dly) begin
      phase_done <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // pomc_io_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench
  import pomc_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        brk_hit = 1'b0;
  logic        cold_start_present = 1'b0;
  logic [7:0]  dly = 8'h08;
  logic [31:0] reg_rdata;
  logic        phase_done;
  pomc_io_t    io_ctl;
  logic        run_led;
  logic        stop_led;
  pomc_mode_t  mode;
  logic [31:0] d;
  int          num_errors = 0;
  int          num_checks = 0;

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  pomc_mode_ctrl #(.BLINK_CYC(200), .WDOG_CYC(100), .HALF_CYC(10)) u_pomc_mode_ctrl (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_done(phase_done),
    .brk_hit(brk_hit), .cold_start_present(cold_start_present), .io_ctl(io_ctl),
    .run_led(run_led), .stop_led(stop_led), .mode(mode));
  pomc_io_model u_pomc_io_model (.clk_sys(clk_sys), .nrst(nrst), .io_ctl(io_ctl),
    .dly(dly), .phase_done(phase_done));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Register bus: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cmd(input int b);
    wr(POMC_ADDR_CTRL, 32'h1 << b);
  endtask
  task automatic wait_mode(input pomc_mode_t m);
    repeat (1000) if (mode !== m) begin
      @(posedge clk_sys);
      #1;
    end
    chk("mode", 32'(mode), 32'(m));
  endtask

  task automatic t_reset();
    chk("mode", 32'(mode), 32'(POMC_STOP));
    chk("od", 32'(io_ctl.output_disable), 32'h1);
    chk("stop led", 32'(stop_led), 32'h1);
    rd(4'hF);
    chk("unmapped", d, 32'h0);
    wr(POMC_ADDR_CYCLIM, 32'h0000_0010);
    rd(POMC_ADDR_CYCLIM);
    chk("cyclim", d, POMC_CYCLIM_RST);
  endtask
  task automatic t_start();
    int  n;
    logic l;
    cmd(POMC_CTRL_RUN_REQ);
    chk("mode", 32'(mode), 32'(POMC_STARTUP));
    chk("clr in", 32'(io_ctl.clr_input_image), 32'h1);
    wait_mode(POMC_RUN);
    chk("od", 32'(io_ctl.output_disable), 32'h0);
    chk("clr out", 32'(io_ctl.clr_output_image), 32'h1);
    chk("timers", 32'(io_ctl.timers_enable), 32'h1);
    repeat (40) if (io_ctl.read_input_image !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    chk("read in", 32'(io_ctl.read_input_image), 32'h1);
    n = 0;
    l = run_led;
    repeat (24) begin
      @(posedge clk_sys);
      #1 n += int'(run_led !== l);
      l = run_led;
    end
    chk("blink", 32'(n >= 2), 32'h1);
    repeat (60) if (io_ctl.write_output_image !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    chk("write out", 32'(io_ctl.write_output_image), 32'h1);
  endtask
  task automatic t_hold(input logic [2:0] brk, input logic step_ok);
    wr(POMC_ADDR_BRK, {29'h0, brk});
    repeat (200) if (io_ctl.run_main_cycle_routine !== 1'b0) begin
      @(posedge clk_sys);
      #1;
    end
    repeat (200) if (io_ctl.run_main_cycle_routine !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    brk_hit <= 1'b1;
    @(posedge clk_sys);
    brk_hit <= 1'b0;
    #1 chk("mode", 32'(mode), 32'(POMC_HOLD));
    chk("od", 32'(io_ctl.output_disable), 32'h1);
    rd(POMC_ADDR_STATUS);
    chk("step ok", 32'(d[7]), 32'(step_ok));
    cmd(POMC_CTRL_STEP);
    chk("mode", 32'(mode), step_ok ? 32'(POMC_RUN) : 32'(POMC_HOLD));
    cmd(POMC_CTRL_RESUME);
    wait_mode(POMC_RUN);
    wr(POMC_ADDR_BRK, 32'h0);
  endtask
  task automatic t_stop();
    cmd(POMC_CTRL_STOP_REQ);
    chk("mode", 32'(mode), 32'(POMC_STOP));
    chk("od", 32'(io_ctl.output_disable), 32'h1);
    chk("main", 32'(io_ctl.run_main_cycle_routine), 32'h0);
    cmd(POMC_CTRL_OVR_RESET);
    @(posedge clk_sys);
    #1 chk("erase", 32'(io_ctl.erase_user_memory), 32'h1);
  endtask
  task automatic t_watchdog();
    @(posedge clk_sys);
    dly <= 8'd150;
    cmd(POMC_CTRL_RUN_REQ);
    repeat (20) @(posedge clk_sys);
    wait_mode(POMC_STOP);
    rd(POMC_ADDR_STATUS);
    chk("wd err", 32'(d[5]), 32'h1);
    @(posedge clk_sys);
    dly <= 8'h08;
    cold_start_present <= 1'b1;
    cmd(POMC_CTRL_RUN_REQ);
    chk("mode", 32'(mode), 32'(POMC_STOP));
    cmd(POMC_CTRL_COLD_OK);
    chk("mode", 32'(mode), 32'(POMC_STARTUP));
    @(posedge clk_sys);
    #1 chk("cold", 32'(io_ctl.run_cold_start_routine), 32'h1);
    wait_mode(POMC_RUN);
    rd(POMC_ADDR_STATUS);
    chk("wd clr", 32'(d[5]), 32'h0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    t_reset();
    t_start();
    t_hold(3'h3, 1'b1);
    t_hold(3'h7, 1'b0);
    t_stop();
    t_watchdog();
    report_and_stop();
  end
  // Hang guard
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule // testbench
